// file: verilog/acs_sequencer.sv
// conversion sequencer: start delay, chop, ac excitation, power-down, reset timing
// How it works
// - programmable start delay, default 50 us
// - chop inverts input polarity each conversion
// - chop discards first conversion after start
// - chop output is half consecutive difference
// - chop first result takes double latency
// - drive outputs follow conversion phase polarity
// - reversed phase inverts reference, then subtracts
// - drives never both active, gap between
// - drives toggle once per conversion only
// - mode 10 two-wire, 11 four-wire
// - gpio0/1 carry a/b, 2/3 repeat in four-wire only
// - clock 10.24 MHz only at 40k
// - auto clock selection, reported in status
// - sleep pin low disables, keeps registers
// - config three bit 7 software sleep
// - reset pin reinitialises everything, command reset only the conversion state
// - any reset sets sticky flag
// - start high at reset end converts
// - ready held low 2^16 cycles
// - first conversion 512 cycles after ready
// - command reset: 512 cycles; pin reset runs the 2^16 wait first
// - ready high at start, low at result
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic sleep_request_i,
   input wire logic cmd_reset_i,
   input wire logic flag_clear_i,
   input wire logic [15:0] delay_cycles_i,
   input wire logic [7:0] config_reg_three_i,
   input wire logic [1:0] polarity_mode_i,
   input wire logic [9:0] rate_code_i,
   input wire logic ext_clock_in_i,
   input wire logic [23:0] raw_result_i,
   output logic result_ready_n_o,
   output logic [23:0] result_data_o,
   output logic chop_invert_o,
   output logic ref_invert_o,
   output logic excite_drive_a_o,
   output logic excite_drive_b_o,
   output logic [3:0] gpio_o,
   output logic clk_fast_o,
   output logic ext_clock_sel_o,
   output logic reset_flag_o,
   output logic powered_o
);
   acs_state_s s_reg;
   acs_state_s s_next;
   logic chop_on;
   logic ac_on;
   logic sleeping;
   logic [24:0] diff;
   logic [24:0] newer;
   logic [24:0] older;
   logic start_level;
   logic sleep_level;
   logic clk_moved;
   localparam logic [16:0] POR_LAST = 17'(POR_CYCLES - 1);

   // start is a level; pulses shorter than two clocks never reach the sequence
   acs_pin_sync #(
      .RESET_LEVEL(1'b0)
   ) i_acs_pin_sync_start (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(start_i),
      .level_o(start_level),
      .moved_o()
   );

   // idles awake, so leaving reset never reads as a sleep request
   acs_pin_sync #(
      .RESET_LEVEL(1'b1)
   ) i_acs_pin_sync_sleep (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(sleep_request_i),
      .level_o(sleep_level),
      .moved_o()
   );

   // only movement matters here, a running clock never holds a level
   acs_pin_sync #(
      .RESET_LEVEL(1'b0)
   ) i_acs_pin_sync_clock (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(ext_clock_in_i),
      .level_o(),
      .moved_o(clk_moved)
   );

   assign chop_on = (polarity_mode_i == POL_CHOP);
   assign ac_on = (polarity_mode_i == POL_AC2) || (polarity_mode_i == POL_AC4);
   assign sleeping = !sleep_level || config_reg_three_i[SLEEP_BIT];

   always_comb begin
      s_next = s_reg;
      diff = 25'h000_0000;
      newer = {raw_result_i[23], raw_result_i};
      older = {s_reg.prev[23], s_reg.prev};
      // external clock present when its sampled level moves
      if (clk_moved) begin
         s_next.ext_sel = 1'b1;
      end
      if (flag_clear_i) begin
         s_next.rst_flag = 1'b0;
      end
      s_next.powered = !sleeping;
      if (cmd_reset_i) begin
         // command reset reinitialises conversion state; set wins over clear
         s_next.st = ACS_WAKE;
         s_next.cnt = 17'(START_CYC);
         s_next.rst_flag = 1'b1;
         s_next.rdy_n = 1'b1;
         s_next.drv_a = 1'b0;
         s_next.drv_b = 1'b0;
         s_next.phase = 1'b0;
         s_next.first = 1'b1;
         s_next.data = 24'h00_0000;
         s_next.prev = 24'h00_0000;
      end else if (sleeping && s_reg.st != ACS_POR) begin
         // sleep stops the sequence but keeps data and settings
         s_next.st = ACS_IDLE;
         s_next.drv_a = 1'b0;
         s_next.drv_b = 1'b0;
      end else begin
         unique case (s_reg.st)
            ACS_POR: begin
               if (s_reg.cnt == POR_LAST) begin
                  s_next.rdy_n = 1'b1;
                  s_next.st = ACS_WAKE;
                  s_next.cnt = 17'(START_CYC);
               end else begin
                  s_next.cnt = s_reg.cnt + 17'h0_0001;
               end
            end
            ACS_WAKE: begin
               if (s_reg.cnt <= 17'h0_0001) begin
                  s_next.st = ACS_IDLE;
               end else begin
                  s_next.cnt = s_reg.cnt - 17'h0_0001;
               end
            end
            ACS_IDLE: begin
               if (start_level) begin
                  s_next.st = ACS_DELAY;
                  if (delay_cycles_i == 16'h0000) begin
                     s_next.dly = DELAY_DEF_CYC;
                  end else begin
                     s_next.dly = delay_cycles_i;
                  end
                  s_next.rdy_n = 1'b1;
                  s_next.first = 1'b1;
                  s_next.phase = 1'b0;
               end
            end
            ACS_DELAY: begin
               if (s_reg.dly <= 16'h0001) begin
                  s_next.st = ACS_CONV;
                  s_next.cnt = 17'(CONV_CYC);
                  s_next.drv_a = ac_on && !s_reg.phase;
                  s_next.drv_b = ac_on && s_reg.phase;
               end else begin
                  s_next.dly = s_reg.dly - 16'h0001;
               end
            end
            ACS_CONV: begin
               if (s_reg.cnt <= 17'h0_0001) begin
                  if ((chop_on || ac_on) && s_reg.first) begin
                     s_next.first = 1'b0;
                  end else if (chop_on || ac_on) begin
                     // normal phase minus reversed phase, so the offset cancels whichever came first
                     if (s_reg.phase) begin
                        diff = older - newer;
                     end else begin
                        diff = newer - older;
                     end
                     s_next.data = diff[24:1];
                     s_next.rdy_n = 1'b0;
                  end else begin
                     s_next.data = raw_result_i;
                     s_next.rdy_n = 1'b0;
                  end
                  s_next.prev = raw_result_i;
                  s_next.phase = !s_reg.phase;
                  s_next.drv_a = 1'b0;
                  s_next.drv_b = 1'b0;
                  s_next.st = ACS_GAP;
                  s_next.cnt = 17'(GAP_CYC);
               end else begin
                  s_next.cnt = s_reg.cnt - 17'h0_0001;
               end
            end
            ACS_GAP: begin
               if (s_reg.cnt <= 17'h0_0001) begin
                  if (start_level) begin
                     s_next.st = ACS_DELAY;
                     if (delay_cycles_i == 16'h0000) begin
                        s_next.dly = DELAY_DEF_CYC;
                     end else begin
                        s_next.dly = delay_cycles_i;
                     end
                     s_next.rdy_n = 1'b1;
                  end else begin
                     s_next.st = ACS_IDLE;
                  end
               end else begin
                  s_next.cnt = s_reg.cnt - 17'h0_0001;
               end
            end
            default: begin
               s_next.st = ACS_IDLE;
            end
         endcase
      end

      // pin-side outputs are registered with the phase and drives they follow, so all move on one edge
      s_next.chop_inv = chop_on && s_next.phase;
      s_next.ref_inv = ac_on && s_next.phase;
      // four-wire repeats phases; unused pins stay low
      s_next.gpio[0] = s_next.drv_a;
      s_next.gpio[1] = s_next.drv_b;
      s_next.gpio[2] = (polarity_mode_i == POL_AC4) && s_next.drv_a;
      s_next.gpio[3] = (polarity_mode_i == POL_AC4) && s_next.drv_b;
      s_next.clk_fast = (rate_code_i == CLK_ID_40K);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '0;
         s_reg.st <= ACS_POR;
         s_reg.rst_flag <= 1'b1;
         s_reg.dly <= DELAY_DEF_CYC;
         s_reg.powered <= 1'b1;
         s_reg.first <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign result_ready_n_o = s_reg.rdy_n;
   assign result_data_o = s_reg.data;
   assign chop_invert_o = s_reg.chop_inv;
   assign ref_invert_o = s_reg.ref_inv;
   assign excite_drive_a_o = s_reg.drv_a;
   assign excite_drive_b_o = s_reg.drv_b;
   assign gpio_o = s_reg.gpio;
   assign clk_fast_o = s_reg.clk_fast;
   assign ext_clock_sel_o = s_reg.ext_sel;
   assign reset_flag_o = s_reg.rst_flag;
   assign powered_o = s_reg.powered;
endmodule

// three-stage pin synchroniser; the level moves only once the last two stages agree
module acs_pin_sync
   import acs_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic moved_o
);
   acs_sync_s s_reg;
   acs_sync_s s_next;

   always_comb begin
      s_next = s_reg;
      s_next.stages = {s_reg.stages[1:0], pin_i};
      if (s_reg.stages[2] == s_reg.stages[1]) begin
         s_next.level = s_reg.stages[2];
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg.stages <= {3{RESET_LEVEL}};
         s_reg.level <= RESET_LEVEL;
      end else begin
         s_reg <= s_next;
      end
   end

   assign level_o = s_reg.level;
   // raw movement between the settled stages, for inputs that never hold still
   assign moved_o = (s_reg.stages[2] != s_reg.stages[1]);
endmodule
`default_nettype wire

// file: verilog/acs_pkg.sv
// package of constants and types for the conversion sequencer
package acs_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned DELAY_DEF_US = 50;
   localparam logic [15:0] DELAY_DEF_CYC = 16'(((DELAY_DEF_US * (CLK_HZ / 1000000)) + 0));
   localparam int unsigned POR_CYC = 65536;
   localparam logic [9:0] START_CYC = 10'h0200;
   localparam logic [7:0] GAP_CYC = 8'h04;
   localparam logic [15:0] CONV_CYC = 16'h0100;
   localparam logic [1:0] POL_CHOP = 2'h1;
   localparam logic [1:0] POL_AC2 = 2'h2;
   localparam logic [1:0] POL_AC4 = 2'h3;
   localparam int unsigned SLEEP_BIT = 7;
   localparam logic [9:0] CLK_ID_40K = 10'h0000;

   typedef enum logic [2:0] {
      ACS_POR = 3'b000,
      ACS_WAKE = 3'b001,
      ACS_IDLE = 3'b010,
      ACS_DELAY = 3'b011,
      ACS_CONV = 3'b100,
      ACS_GAP = 3'b101
   } acs_state_e;

   typedef struct packed {
      acs_state_e st;
      logic [16:0] cnt;
      logic [15:0] dly;
      logic phase;
      logic first;
      logic [23:0] prev;
      logic [23:0] data;
      logic rdy_n;
      logic drv_a;
      logic drv_b;
      logic rst_flag;
      logic ext_sel;
      logic powered;
      logic chop_inv;
      logic ref_inv;
      logic [3:0] gpio;
      logic clk_fast;
   } acs_state_s;

   typedef struct packed {
      logic [2:0] stages;
      logic level;
   } acs_sync_s;
endpackage

// file: tb/acs_seq_checker.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_seq_checker
   import acs_pkg::*;
#(parameter int unsigned POR_CYCLES = POR_CYC) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic sleep_request_i,
   input wire logic cmd_reset_i,
   input wire logic [7:0] config_reg_three_i,
   input wire logic [1:0] polarity_mode_i,
   input wire logic [9:0] rate_code_i,
   input wire logic result_ready_n_o,
   input wire logic excite_drive_a_o,
   input wire logic excite_drive_b_o,
   input wire logic [3:0] gpio_o,
   input wire logic clk_fast_o,
   input wire logic reset_flag_o,
   input wire logic ref_invert_o,
   input wire logic powered_o
);
   logic [16:0] cnt_reg;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // saturates so the early-ready check covers only the start-up span
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) cnt_reg <= 17'h0_0000;
      else if (cnt_reg != 17'h1_ffff) cnt_reg <= cnt_reg + 17'h0_0001;
   end
   por_ready_low_a: assert property (cnt_reg < 17'(POR_CYCLES - 1) |-> !result_ready_n_o)
      else $error("ready early");
   drives_apart_a: assert property (!(excite_drive_a_o && excite_drive_b_o)) else $error("drive overlap");
   drive_gap_a: assert property ($fell(excite_drive_a_o) |-> !excite_drive_b_o [*3]) else $error("no gap");
   drive_holds_a: assert property ($rose(excite_drive_a_o) |=> excite_drive_a_o [*8]) else $error("fast drive");
   gpio_pair_a: assert property (gpio_o[1:0] == {excite_drive_b_o, excite_drive_a_o}) else $error("gpio low");
   gpio_four_a: assert property (gpio_o[3:2] == (($past(polarity_mode_i) == POL_AC4) ? gpio_o[1:0] : 2'h0))
      else $error("gpio high");
   clk_fast_a: assert property (clk_fast_o == ($past(rate_code_i) == CLK_ID_40K)) else $error("clock rate");
   ref_reverse_a: assert property (excite_drive_b_o |-> ref_invert_o) else $error("ref not reversed");
   flag_cmd_a: assert property (cmd_reset_i |=> reset_flag_o) else $error("flag cmd");
   flag_pin_a: assert property ($rose(reset_n_i) |-> reset_flag_o) else $error("flag pin");
   hw_sleep_a: assert property (!sleep_request_i |-> ##[5:6] !powered_o) else $error("hw sleep");
   sw_sleep_a: assert property (config_reg_three_i[SLEEP_BIT] |-> ##[1:2] !powered_o) else $error("sw sleep");
   cover property ($fell(result_ready_n_o));
   cover property ($rose(excite_drive_b_o));
   cover property (cmd_reset_i);
endmodule
bind acs_sequencer acs_seq_checker #(.POR_CYCLES(POR_CYCLES)) i_acs_seq_checker (.sys_clk_i(sys_clk_i),
   .reset_n_i(reset_n_i), .sleep_request_i(sleep_request_i), .cmd_reset_i(cmd_reset_i),
   .config_reg_three_i(config_reg_three_i), .polarity_mode_i(polarity_mode_i), .rate_code_i(rate_code_i),
   .result_ready_n_o(result_ready_n_o), .excite_drive_a_o(excite_drive_a_o), .excite_drive_b_o(excite_drive_b_o),
   .gpio_o(gpio_o), .clk_fast_o(clk_fast_o), .reset_flag_o(reset_flag_o), .powered_o(powered_o),
   .ref_invert_o(ref_invert_o));
`default_nettype wire

// file: tb/acs_front_model.sv
// front-end model: filter result by chop phase with a fixed offset
`timescale 1ns/1ps
`default_nettype none
module acs_front_model #(
   parameter logic [23:0] SIG = 24'h00_1234,
   parameter logic [23:0] OFS = 24'h00_0056
) (
   input wire logic chop_invert_i,
   output logic [23:0] raw_result_o
);
   // offset keeps its sign in both phases, so only a correct pair difference cancels it
   assign raw_result_o = chop_invert_i ? (24'h00_0000 - SIG - OFS) : (SIG - OFS);
endmodule
`default_nettype wire

// file: tb/acs_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_test;
   import acs_pkg::*;
   localparam int unsigned POR_SIM = 64;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b1, slp = 1'b1, cmd = 1'b0, clr = 1'b0, ext = 1'b0;
   logic [15:0] dly = 16'h000a;
   logic [7:0] cfg3 = 8'h00;
   logic [1:0] pol = POL_AC4;
   logic [9:0] rate = 10'h0005;
   logic [23:0] raw, data;
   logic rdy_n, inv, drv_a, drv_b, fast, ext_sel, flag, pwr;
   int errors = 0, total_checks = 0, n = 0;
   always #25 clk = ~clk;
   acs_sequencer #(.POR_CYCLES(POR_SIM)) i_acs_sequencer (.sys_clk_i(clk), .reset_n_i(rst_n), .start_i(start),
      .sleep_request_i(slp), .cmd_reset_i(cmd), .flag_clear_i(clr), .delay_cycles_i(dly), .config_reg_three_i(cfg3),
      .polarity_mode_i(pol), .rate_code_i(rate), .ext_clock_in_i(ext), .raw_result_i(raw), .result_ready_n_o(rdy_n),
      .result_data_o(data), .chop_invert_o(inv), .ref_invert_o(), .excite_drive_a_o(drv_a),
      .excite_drive_b_o(drv_b), .gpio_o(), .clk_fast_o(fast), .ext_clock_sel_o(ext_sel), .reset_flag_o(flag),
      .powered_o(pwr));
   acs_front_model i_acs_front_model (.chop_invert_i(inv), .raw_result_o(raw));
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // counts falling edges until the chosen output reaches the level
   task automatic wait_sig(input int sel, input logic lvl);
      n = 0;
      while ((sel == 0 ? rdy_n : (sel == 1 ? drv_a : drv_b)) !== lvl) begin
         @(negedge clk);
         n++;
         if (n > 5000) begin
            check("wait bound", 24'h00_0001, 24'h00_0000);
            report_and_stop();
         end
      end
   endtask
   task automatic span(input string what, input int lo, input int hi);
      check(what, 24'h00_0001, 24'(n >= lo && n <= hi));
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check("flag at start", 24'h00_0001, 24'(flag));
      wait_sig(0, 1'b1);
      span("ready low span", POR_SIM, POR_SIM + 1);
      wait_sig(1, 1'b1);
      span("first start", 522, 532);
      wait_sig(2, 1'b1);
      span("reverse phase", 264, 276);
      wait_sig(0, 1'b0);
      span("double latency", 250, 262);
      wait_sig(0, 1'b1);
      span("next start", 1, 8);
      @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      check("flag cleared", 24'h00_0000, 24'(flag));
      cmd = 1'b1;
      @(negedge clk);
      cmd = 1'b0;
      check("flag cmd", 24'h00_0001, 24'(flag));
      wait_sig(1, 1'b1);
      span("cmd restart", 515, 530);
      pol = POL_CHOP;
      for (int i = 0; i < 2; i++) begin
         wait_sig(0, 1'b0);
         check("chop result", 24'h00_1234, data);
         wait_sig(0, 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
         slp = (i != 0);
         cfg3 = (i == 2) ? 8'h80 : 8'h00;
         repeat (8) @(negedge clk);
         check("powered", 24'(i[0]), 24'(pwr));
      end
      check("flag kept", 24'h00_0001, 24'(flag));
      rate = 10'h0000;
      check("ext sel idle", 24'h00_0000, 24'(ext_sel));
      repeat (8) begin
         @(negedge clk);
         ext = ~ext;
      end
      repeat (4) @(negedge clk);
      check("fast clock", 24'h00_0001, 24'(fast));
      check("ext sel", 24'h00_0001, 24'(ext_sel));
      report_and_stop();
   end
endmodule
`default_nettype wire
